// *** design/ddw_pacer.sv ***
// Two-channel DAC pacer: single-value writes, buffered waveform output
//
// Contract
// (R1) Two 16-bit channels, software-selected output range
// (R2) Mode selected per channel
// (R3) Single-value write updates converter at once
// (R4) Waveform channels update together per pacing event
// (R5) Up to 3 MS/s, one or both channels
// (R6) Host sets clock, trigger, fills buffer first
// (R7) After trigger, one sample per pacing event
// (R8) Draining buffer interrupts host; host refills
// (R9) Runs until data sent or software stop
// (R10) Both channels: even to ch0, odd to ch1
// (R11) Internal pace from 32-bit divider of time base
// (R12) Internal pacing rate capped at 3 MS/s
// (R13) External clock rising edge paces updates
// (R14) External clock kept at or below 3 MS/s; extTick paces on every synchronised rising edge, with no rate limit
// (R15) Trigger is an edge on trigger input
// (R16) Trigger edge polarity software selectable
// (R17) Codes are straight 16-bit binary
// (R18) External inputs synchronised, edges become pulses
// (R19) Low-watermark interrupt, cleared by software
`timescale 1ns/1ps
module ddw_pacer #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extTrig,
  input wire logic extClk,
  output logic [15:0] dacCode0,
  output logic [15:0] dacCode1,
  output logic [1:0] dacLoad,
  output logic [2:0] rangeCh0,
  output logic [2:0] rangeCh1,
  output logic irq
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  ddw_pkg::ddw_ctrl_s ctrl_q;
  ddw_pkg::ddw_state_e state_q;
  logic [31:0] div_q;
  logic [31:0] count_q;
  logic [31:0] remain_q;
  logic [31:0] divCnt_q;
  logic [AW:0] wmark_q;
  logic [AW:0] lvl_q;
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [15:0] mem [DEPTH];
  logic [ddw_pkg::ST_W-1:0] stat_q;
  logic [ddw_pkg::ST_W-1:0] mask_q;
  logic [ddw_pkg::ST_W-1:0] rdStat_q;
  logic [2:0] trigSync_q;
  logic [2:0] clkSync_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [15:0] code0_q;
  logic [15:0] code1_q;
  logic [1:0] load_q;
  logic irq_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= ddw_pkg::OFF_COUNT);
  endfunction

  function automatic logic [AW-1:0] ptrAdd(input logic [AW-1:0] p, input logic [1:0] n);
    ptrAdd = p + AW'(n);
  endfunction

  logic setup;
  logic access;
  logic wrEn;
  logic rdEn;
  logic fifoFull;
  logic pushOk;
  assign setup = psel && !penable;
  assign access = psel && penable && pready_q;
  assign wrEn = access && pwrite && !pslverr_q;
  assign rdEn = access && !pwrite;
  assign fifoFull = (lvl_q == (AW+1)'(DEPTH));
  assign pushOk = wrEn && (paddr == ddw_pkg::OFF_FIFO);

  logic startReq;
  logic stopReq;
  assign startReq = wrEn && (paddr == ddw_pkg::OFF_CTRL) && pwdata[ddw_pkg::CTRL_START_BIT];
  assign stopReq = wrEn && (paddr == ddw_pkg::OFF_CTRL) && pwdata[ddw_pkg::CTRL_STOP_BIT];

  // ----------------------------------------------------------------
  // External input synchronisers
  // ----------------------------------------------------------------
  // Stage 0 feeds only stage 1; edges are taken between stages 1 and 2
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trigSync_q <= 3'h0;
      clkSync_q <= 3'h0;
    end else begin
      trigSync_q <= {trigSync_q[1:0], extTrig}; // R18
      clkSync_q <= {clkSync_q[1:0], extClk}; // R18
    end
  end

  logic trigEdge;
  logic extTick;
  // R15 R16
  assign trigEdge = ctrl_q.trigFall ? (trigSync_q[2] && !trigSync_q[1])
                                    : (!trigSync_q[2] && trigSync_q[1]);
  // R13 R14
  assign extTick = clkSync_q[1] && !clkSync_q[2];

  // ----------------------------------------------------------------
  // Pacing divider
  // ----------------------------------------------------------------
  logic [31:0] divEff;
  logic intTick;
  logic paceTick;
  // Clamp keeps the internal rate within the converter limit
  assign divEff = (div_q < ddw_pkg::MIN_DIV) ? ddw_pkg::MIN_DIV : div_q; // R12
  assign intTick = (divCnt_q == 32'h0000_0001);
  assign paceTick = (state_q == ddw_pkg::PS_RUN) && (ctrl_q.extClk ? extTick : intTick);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      divCnt_q <= 32'h0000_0000;
    end else if (state_q != ddw_pkg::PS_RUN) begin
      divCnt_q <= divEff; // R11
    end else if (intTick) begin
      divCnt_q <= divEff; // R11
    end else begin
      divCnt_q <= divCnt_q - 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Waveform sequencing
  // ----------------------------------------------------------------
  logic both;
  logic anyWave;
  logic [1:0] need;
  logic canPop;
  logic doPop;
  logic lastPop;
  assign both = ctrl_q.waveCh0 && ctrl_q.waveCh1;
  assign anyWave = ctrl_q.waveCh0 || ctrl_q.waveCh1;
  assign need = both ? 2'h2 : 2'h1; // R5
  assign canPop = (lvl_q >= (AW+1)'(need));
  assign doPop = paceTick && canPop;
  assign lastPop = doPop && (count_q != 32'h0000_0000) && (remain_q <= 32'(need));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ddw_pkg::PS_IDLE;
    end else begin
      unique case (state_q)
        ddw_pkg::PS_IDLE: begin
          if (startReq && !stopReq && anyWave) begin
            state_q <= ddw_pkg::PS_ARMED; // R6
          end
        end
        ddw_pkg::PS_ARMED: begin
          if (stopReq) begin
            state_q <= ddw_pkg::PS_IDLE;
          end else if (trigEdge) begin
            state_q <= ddw_pkg::PS_RUN; // R7 R15
          end
        end
        ddw_pkg::PS_RUN: begin
          if (stopReq || lastPop) begin
            state_q <= ddw_pkg::PS_IDLE; // R9
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      remain_q <= 32'h0000_0000;
    end else if (state_q == ddw_pkg::PS_ARMED) begin
      remain_q <= count_q;
    end else if (doPop && (remain_q >= 32'(need))) begin
      remain_q <= remain_q - 32'(need); // R9
    end
  end

  // ----------------------------------------------------------------
  // Sample buffer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (pushOk) begin
      mem[wrPtr_q] <= pwdata[15:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      lvl_q <= '0;
    end else begin
      if (pushOk) begin
        wrPtr_q <= ptrAdd(wrPtr_q, 2'h1);
      end
      if (doPop) begin
        rdPtr_q <= ptrAdd(rdPtr_q, need);
      end
      lvl_q <= lvl_q + (AW+1)'(pushOk) - (doPop ? (AW+1)'(need) : '0);
    end
  end

  // ----------------------------------------------------------------
  // Converter codes
  // ----------------------------------------------------------------
  // Codes pass through unchanged; range outputs set the scaling
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      code0_q <= ddw_pkg::CODE_RESET;
      code1_q <= ddw_pkg::CODE_RESET;
      load_q <= 2'h0;
    end else begin
      load_q <= 2'h0;
      if (wrEn && (paddr == ddw_pkg::OFF_DATA0) && !ctrl_q.waveCh0) begin
        code0_q <= pwdata[15:0]; // R3 R17
        load_q[0] <= 1'b1; // R3
      end
      if (wrEn && (paddr == ddw_pkg::OFF_DATA1) && !ctrl_q.waveCh1) begin
        code1_q <= pwdata[15:0]; // R3 R17
        load_q[1] <= 1'b1; // R3
      end
      if (doPop) begin
        if (both) begin
          code0_q <= mem[rdPtr_q]; // R10
          code1_q <= mem[ptrAdd(rdPtr_q, 2'h1)]; // R10
          load_q <= 2'h3; // R4
        end else if (ctrl_q.waveCh0) begin
          code0_q <= mem[rdPtr_q]; // R7
          load_q[0] <= 1'b1;
        end else begin
          code1_q <= mem[rdPtr_q]; // R7
          load_q[1] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q <= '0;
      div_q <= ddw_pkg::DIV_RESET;
      count_q <= 32'h0000_0000;
      mask_q <= '0;
      wmark_q <= '0;
    end else if (wrEn) begin
      unique case (paddr)
        ddw_pkg::OFF_CTRL: ctrl_q <= pwdata[ddw_pkg::CTRL_W-1:0]; // R1 R2
        ddw_pkg::OFF_DIV: div_q <= pwdata; // R11
        ddw_pkg::OFF_COUNT: count_q <= pwdata;
        ddw_pkg::OFF_MASK: mask_q <= pwdata[ddw_pkg::ST_W-1:0];
        ddw_pkg::OFF_WMARK: wmark_q <= pwdata[AW:0]; // R19
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  logic [ddw_pkg::ST_W-1:0] evt;
  logic [AW:0] lvlNext;
  assign lvlNext = lvl_q + (AW+1)'(pushOk) - (doPop ? (AW+1)'(need) : '0);
  always_comb begin
    evt = '0;
    evt[ddw_pkg::ST_WMARK] = doPop && (lvl_q > wmark_q) && (lvlNext <= wmark_q); // R8 R19
    evt[ddw_pkg::ST_DONE] = lastPop;
    evt[ddw_pkg::ST_UNDER] = paceTick && !canPop;
    evt[ddw_pkg::ST_TRIG] = (state_q == ddw_pkg::PS_ARMED) && trigEdge && !stopReq;
  end

  // Only bits already returned to software are cleared, so a new event wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stat_q <= '0;
    end else if (rdEn && (paddr == ddw_pkg::OFF_STAT)) begin
      stat_q <= (stat_q & ~rdStat_q) | evt; // R19
    end else begin
      stat_q <= stat_q | evt; // R8
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |((stat_q | evt) & mask_q &
                 ~((rdEn && (paddr == ddw_pkg::OFF_STAT)) ? rdStat_q : '0)); // R8
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one-cycle access phase, read data captured at setup
  // ----------------------------------------------------------------
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (paddr)
      ddw_pkg::OFF_CTRL: rdMux[ddw_pkg::CTRL_W-1:0] = ctrl_q;
      ddw_pkg::OFF_DIV: rdMux = div_q;
      ddw_pkg::OFF_DATA0: rdMux[15:0] = code0_q;
      ddw_pkg::OFF_DATA1: rdMux[15:0] = code1_q;
      ddw_pkg::OFF_STAT: rdMux[ddw_pkg::ST_W-1:0] = stat_q;
      ddw_pkg::OFF_MASK: rdMux[ddw_pkg::ST_W-1:0] = mask_q;
      ddw_pkg::OFF_WMARK: rdMux[AW:0] = wmark_q;
      ddw_pkg::OFF_STATE: begin
        rdMux[2:0] = state_q;
        rdMux[ddw_pkg::STATE_LVL_LSB +: AW+1] = lvl_q;
      end
      ddw_pkg::OFF_COUNT: rdMux = remain_q;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      rdStat_q <= '0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rdMux;
        rdStat_q <= (!pwrite && paddr == ddw_pkg::OFF_STAT) ? stat_q : '0;
        // Unmapped offsets and pushes into a full buffer are refused
        pslverr_q <= !mapped(paddr) ||
                     (pwrite && paddr == ddw_pkg::OFF_FIFO && fifoFull);
      end else if (access) begin
        pslverr_q <= 1'b0;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign dacCode0 = code0_q;
  assign dacCode1 = code1_q;
  assign dacLoad = load_q;
  assign rangeCh0 = ctrl_q.rangeCh0; // R1
  assign rangeCh1 = ctrl_q.rangeCh1; // R1
  assign irq = irq_q;

endmodule

// *** design/ddw_pkg.sv ***
// Package: register map, field layout and timing constants of the pacer
package ddw_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DIV = 8'h04;
  localparam logic [7:0] OFF_DATA0 = 8'h08;
  localparam logic [7:0] OFF_DATA1 = 8'h0C;
  localparam logic [7:0] OFF_FIFO = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_MASK = 8'h18;
  localparam logic [7:0] OFF_WMARK = 8'h1C;
  localparam logic [7:0] OFF_STATE = 8'h20;
  localparam logic [7:0] OFF_COUNT = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_W = 10;
  localparam int CTRL_START_BIT = 16;
  localparam int CTRL_STOP_BIT = 17;
  localparam int ST_WMARK = 0;
  localparam int ST_DONE = 1;
  localparam int ST_UNDER = 2;
  localparam int ST_TRIG = 3;
  localparam int ST_W = 4;
  localparam int STATE_LVL_LSB = 16;

  // Range codes 0..3 internal, 4 external reference
  localparam logic [2:0] RANGE_U5 = 3'h0;
  localparam logic [2:0] RANGE_U10 = 3'h1;
  localparam logic [2:0] RANGE_B5 = 3'h2;
  localparam logic [2:0] RANGE_B10 = 3'h3;
  localparam logic [2:0] RANGE_EXT = 3'h4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] DIV_RESET = 32'h0000_0064;
  localparam logic [15:0] CODE_RESET = 16'h8000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 50000000;
  localparam longint MAX_RATE_SPS = 3000000;
  // Least divisor, rounded up so the rate never passes the limit
  localparam longint MIN_DIV_L = (CLK_HZ + MAX_RATE_SPS - 1) / MAX_RATE_SPS;
  localparam logic [31:0] MIN_DIV = 32'(MIN_DIV_L);

  typedef struct packed {
    logic [2:0] rangeCh1;
    logic [2:0] rangeCh0;
    logic trigFall;
    logic extClk;
    logic waveCh1;
    logic waveCh0;
  } ddw_ctrl_s;

  typedef enum logic [2:0] {
    PS_IDLE = 3'b001,
    PS_ARMED = 3'b010,
    PS_RUN = 3'b100
  } ddw_state_e;
endpackage

// *** tb/ddw_pacer_properties.sv ***
// Checker: port-level timing properties of the pacer
`timescale 1ns/1ps
module ddw_pacer_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic extTrig,
  input wire logic extClk,
  input wire logic [15:0] dacCode0,
  input wire logic [15:0] dacCode1,
  input wire logic [1:0] dacLoad,
  input wire logic [2:0] rangeCh0,
  input wire logic [2:0] rangeCh1,
  input wire logic irq
);
  logic wr;
  logic w0_q;
  logic w1_q;
  assign wr = psel && penable && pready && pwrite;
  // Mode bits mirrored so mode-dependent rules can be judged
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      w0_q <= 1'b0;
      w1_q <= 1'b0;
    end else if (wr && paddr == ddw_pkg::OFF_CTRL) begin
      w0_q <= pwdata[0];
      w1_q <= pwdata[1];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_SINGLE0: assert property (wr && paddr == ddw_pkg::OFF_DATA0 && !w0_q
    |=> dacLoad[0] && dacCode0 == $past(pwdata[15:0])) else $error("single write lost");
  AST_LOAD_SYNC: assert property (w0_q && w1_q && dacLoad != 2'h0
    |-> dacLoad == 2'h3) else $error("channels updated apart");
  AST_RANGE: assert property (wr && paddr == ddw_pkg::OFF_CTRL
    |=> rangeCh0 == $past(pwdata[6:4]) && rangeCh1 == $past(pwdata[9:7]))
    else $error("range not applied");
  AST_IRQ_MASK: assert property (wr && paddr == ddw_pkg::OFF_MASK && pwdata[3:0] == 4'h0
    |=> ##1 !irq) else $error("masked irq stays high");
  AST_PACE_GAP: assert property (w0_q && w1_q && dacLoad != 2'h0
    |=> (dacLoad == 2'h0) [*8]) else $error("pacing too fast");
  AST_RESET_CODE: assert property ($fell(rst)
    |-> dacCode0 == ddw_pkg::CODE_RESET && dacLoad == 2'h0) else $error("bad reset code");
  AST_PREADY: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready timing");
  AST_SLVERR: assert property (psel && !penable && paddr > 8'h24 |=> pslverr)
    else $error("unmapped not refused");
  AST_CODE_HOLD: assert property (!$stable(dacCode0) |-> dacLoad[0])
    else $error("code moved without load");
endmodule
bind ddw_pacer ddw_pacer_properties chk (.mclk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .extTrig, .extClk, .dacCode0, .dacCode1, .dacLoad,
  .rangeCh0, .rangeCh1, .irq);

// *** tb/ddw_host_model.sv ***
// Host model: APB master that configures the pacer and feeds samples
`timescale 1ns/1ps
module ddw_host_model (
  input wire logic mclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e, output logic to);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    r = prdata;
    e = pslverr;
    to = (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data is scrambled so nobody relies on stale values
    pwdata <= ~d;
  endtask
endmodule

// *** tb/dual_dac_waveform_pacer_tb.sv ***
// Testbench: single-value and waveform runs of the pacer
`timescale 1ns/1ps
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin err_total++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, x); end end
module dual_dac_waveform_pacer_tb;
  logic mclk, rst, extTrig, extClk, extRun, psel, penable, pwrite, pready, pslverr, irq, e, to;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] dacCode0, dacCode1, v, v0;
  logic [1:0] dacLoad;
  logic [2:0] rangeCh0, rangeCh1;
  int err_total, num_checks, seed, cyc, div, gap, k, ph;
  logic [15:0] smp[$];
  logic [49:0] ev[$];
  ddw_pacer uut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .extTrig, .extClk, .dacCode0, .dacCode1, .dacLoad, .rangeCh0, .rangeCh1, .irq);
  ddw_host_model host (.mclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr,
    .pwdata);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (dacLoad !== 2'h0) ev.push_back({dacLoad, dacCode0, dacCode1, cyc[15:0]});
  end
  // Phase restarts with each run so the first period is never cut short
  always @(posedge mclk) begin
    ph <= extRun ? (ph + 1) % 20 : 0;
    extClk <= extRun && (ph >= 10);
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    host.xfer(w, a, d, rd, e, to);
    if (to) begin
      err_total++;
      print_verdict();
    end
  endtask
  task automatic wait_ev(input int n);
    k = 0;
    while (ev.size() < n && k < 2000) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 2000) begin
      err_total++;
      print_verdict();
    end
  endtask
  initial begin
    seed = 85;
    rst = 1'b1;
    extTrig = 1'b0;
    extRun = 1'b0;
    extClk = 1'b0;
    cyc = 0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    `CHK(dacCode0, ddw_pkg::CODE_RESET)
    bus(1'b0, ddw_pkg::OFF_DIV, 32'h0);
    `CHK(rd, ddw_pkg::DIV_RESET)
    bus(1'b0, 8'h30, 32'h0);
    `CHK(e, 1'b1)
    // ---------------------------------------------------------------
    // Single-value mode, every range code, code extremes first
    // ---------------------------------------------------------------
    for (int i = 0; i < 5; i++) begin
      v = (i < 2) ? {16{i[0]}} : 16'($random(seed));
      bus(1'b1, ddw_pkg::OFF_CTRL, {22'h0, 3'(4 - i), 3'(i), 4'h0});
      #1 `CHK(rangeCh0, 3'(i))
      `CHK(rangeCh1, 3'(4 - i))
      bus(1'b1, i[0] ? ddw_pkg::OFF_DATA1 : ddw_pkg::OFF_DATA0, {16'hFFFF, v});
      #1 `CHK(i[0] ? dacCode1 : dacCode0, v)
      `CHK(dacLoad, i[0] ? 2'h2 : 2'h1)
      bus(1'b0, i[0] ? ddw_pkg::OFF_DATA1 : ddw_pkg::OFF_DATA0, 32'h0);
      `CHK(rd, 32'(v))
    end
    // ---------------------------------------------------------------
    // Both channels, internal pace: divisor below floor, then random
    // ---------------------------------------------------------------
    for (int p = 0; p < 2; p++) begin
      div = p ? 17 + ($random(seed) & 15) : 5;
      gap = (div < 17) ? 17 : div;
      smp.delete();
      ev.delete();
      for (int i = 0; i < 12; i++) smp.push_back(16'($random(seed)));
      bus(1'b1, ddw_pkg::OFF_CTRL, 32'h3);
      bus(1'b1, ddw_pkg::OFF_DIV, 32'(div));
      bus(1'b1, ddw_pkg::OFF_WMARK, 32'h2);
      bus(1'b1, ddw_pkg::OFF_MASK, 32'h1);
      bus(1'b1, ddw_pkg::OFF_COUNT, 32'hC);
      for (int i = 0; i < 8; i++) bus(1'b1, ddw_pkg::OFF_FIFO, {16'h0, smp[i]});
      bus(1'b0, ddw_pkg::OFF_STAT, 32'h0);
      bus(1'b1, ddw_pkg::OFF_CTRL, 32'h10003);
      extTrig <= 1'b1;
      wait_ev(3);
      // Refill answers the low-level interrupt
      for (int i = 8; i < 12; i++) bus(1'b1, ddw_pkg::OFF_FIFO, {16'h0, smp[i]});
      `CHK(irq, 1'b1)
      wait_ev(6);
      for (int j = 0; j < 6; j++) begin
        `CHK(ev[j][49:48], 2'h3)
        `CHK(ev[j][47:32], smp[2 * j])
        `CHK(ev[j][31:16], smp[2 * j + 1])
        if (j > 0) `CHK(16'(ev[j][15:0] - ev[j - 1][15:0]), 16'(gap))
      end
      bus(1'b0, ddw_pkg::OFF_STAT, 32'h0);
      `CHK(rd[1:0], 2'h3)
      bus(1'b0, ddw_pkg::OFF_STAT, 32'h0);
      #1 `CHK(rd[1:0], 2'h0)
      `CHK(irq, 1'b0)
      bus(1'b0, ddw_pkg::OFF_STATE, 32'h0);
      `CHK(rd[2:0], 3'h1)
      extTrig <= 1'b0;
    end
    // ---------------------------------------------------------------
    // Channel 0 waveform, external pace, falling trigger, stop
    // ---------------------------------------------------------------
    extTrig <= 1'b1;
    smp.delete();
    for (int i = 0; i < 3; i++) smp.push_back(16'($random(seed)));
    bus(1'b1, ddw_pkg::OFF_CTRL, 32'hD);
    bus(1'b1, ddw_pkg::OFF_COUNT, 32'h0);
    for (int i = 0; i < 3; i++) bus(1'b1, ddw_pkg::OFF_FIFO, {16'h0, smp[i]});
    bus(1'b1, ddw_pkg::OFF_CTRL, 32'h1000D);
    v = 16'($random(seed));
    v0 = dacCode0;
    bus(1'b1, ddw_pkg::OFF_DATA1, {16'h0, v});
    #1 `CHK(dacCode1, v)
    bus(1'b1, ddw_pkg::OFF_DATA0, {16'h0, ~v});
    #1 `CHK(dacCode0, v0)
    extTrig <= 1'b0;
    // Two sync stages pass before the falling edge reaches the sequencer
    repeat (3) @(posedge mclk);
    bus(1'b0, ddw_pkg::OFF_STATE, 32'h0);
    `CHK(rd[2:0], 3'h4)
    // Single-value loads above are not part of the waveform record
    ev.delete();
    extRun <= 1'b1;
    wait_ev(3);
    for (int j = 0; j < 3; j++) begin
      `CHK(ev[j][49:48], 2'h1)
      `CHK(ev[j][47:32], smp[j])
      if (j > 0) `CHK(16'(ev[j][15:0] - ev[j - 1][15:0]), 16'h14)
    end
    repeat (25) @(posedge mclk);
    `CHK(ev.size(), 3)
    extRun <= 1'b0;
    // Underrun is sticky: unmasking it raises the line, masking drops it
    bus(1'b1, ddw_pkg::OFF_MASK, 32'h4);
    @(posedge mclk);
    #1 `CHK(irq, 1'b1)
    bus(1'b1, ddw_pkg::OFF_MASK, 32'h0);
    @(posedge mclk);
    #1 `CHK(irq, 1'b0)
    bus(1'b1, ddw_pkg::OFF_CTRL, 32'h2000D);
    bus(1'b0, ddw_pkg::OFF_STATE, 32'h0);
    `CHK(rd[2:0], 3'h1)
    bus(1'b0, ddw_pkg::OFF_STAT, 32'h0);
    `CHK(rd[2], 1'b1)
    print_verdict();
  end
endmodule
